// File: bfi_defs.svh
// Purpose: Constants of the bit-field insert/fill/test unit
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef BFI_DEFS_SVH
`define BFI_DEFS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define BFI_ADDR_W 8
`define BFI_OFF_CTRL 8'h00
`define BFI_OFF_STATUS 8'h04
`define BFI_OFF_OPWORD 8'h08
`define BFI_OFF_EXT 8'h0C
`define BFI_OFF_CCR 8'h10
`define BFI_OFF_OFFV 8'h14
`define BFI_OFF_WIDV 8'h18
`define BFI_OFF_SRCV 8'h1C
`define BFI_OFF_OPHI 8'h20
`define BFI_OFF_OPLO 8'h24
`define BFI_OFF_RSHI 8'h28
`define BFI_OFF_RSLO 8'h2C
`define BFI_OFF_DISP 8'h30
`define BFI_OFF_INFO 8'h34
// ----------------------------------------
// Fields
// ----------------------------------------
`define BFI_CTRL_START 0
`define BFI_ST_BUSY 0
`define BFI_ST_DONE 1
`define BFI_ST_ILL 2
`define BFI_CCR_C 0
`define BFI_CCR_V 1
`define BFI_CCR_Z 2
`define BFI_CCR_N 3
`define BFI_CCR_X 4
`define BFI_OPC_FIELD 15:6
`define BFI_OPC_INSERT 10'h3BF
`define BFI_OPC_FILL 10'h3BB
`define BFI_OPC_TEST 10'h3A3
`define BFI_EA_MODE 5:3
`define BFI_EA_REG 2:0
`define BFI_EA_DREG 3'h0
`define BFI_EA_INDIR 3'h2
`define BFI_EA_DISP 3'h5
`define BFI_EA_INDEX 3'h6
`define BFI_EA_EXT 3'h7
`define BFI_EA_ABSW 3'h0
`define BFI_EA_ABSL 3'h1
`define BFI_EA_PCDISP 3'h2
`define BFI_EA_PCIDX 3'h3
`define BFI_X_TOP 15
`define BFI_X_SRC 14:12
`define BFI_X_DO 11
`define BFI_X_OFF 10:6
`define BFI_X_ORSV 10:9
`define BFI_X_OREG 8:6
`define BFI_X_DW 5
`define BFI_X_WID 4:0
`define BFI_X_WRSV 4:3
`define BFI_X_WREG 2:0
// ----------------------------------------
// Widths and codes
// ----------------------------------------
`define BFI_FULL_W 6'h20
`define BFI_REG_W 7'h20
`define BFI_WIN_W 7'h40
`define BFI_BYTE_SH 3
`define BFI_RESP_OKAY 2'h0
`define BFI_RESP_SLVERR 2'h2
`endif

// File: bfi_pkg.sv
// Purpose: Types of the bit-field unit
// Assumes: Nothing
// Notes: States are one-hot
package bfi_pkg;
	typedef enum logic [1:0] {
		BFI_ST_IDLE = 2'h1,
		BFI_ST_EXEC = 2'h2
	} bfi_state_t;
	typedef enum logic [1:0] {
		BFI_OP_INS = 2'h0,
		BFI_OP_FILL = 2'h1,
		BFI_OP_TEST = 2'h2,
		BFI_OP_BAD = 2'h3
	} bfi_op_t;
endpackage

// File: bfi_reg_if.sv
// Purpose: Register access between bus slave and register file
// Assumes: One clock
// Notes: Read data is combinational from the register side
`timescale 1ns/1ps
`default_nettype none
interface bfi_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_hit;
	modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input wr_hit, rd_data, rd_hit);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

// File: bfi_axil_slave.sv
// Purpose: AXI4-Lite slave front end
// Assumes: One write and one read outstanding at most
// Notes: Unmapped addresses answer SLVERR
`timescale 1ns/1ps
`default_nettype none
`include "bfi_defs.svh"
module bfi_axil_slave (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Write channels
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	// Read channels
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [7:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	// Register side
	bfi_reg_if.bus bus
);
	logic aw_got_reg, w_got_reg;
	// ----------------------------------------
	// Write path
	// ----------------------------------------
	assign bus.wr_en = aw_got_reg && w_got_reg && !o_s_axi_bvalid;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_s_axi_awready <= 1'b0;
			aw_got_reg <= 1'b0;
			bus.wr_addr <= 8'h00;
		end else if (i_s_axi_awvalid && o_s_axi_awready) begin
			o_s_axi_awready <= 1'b0;
			aw_got_reg <= 1'b1;
			bus.wr_addr <= i_s_axi_awaddr;
		end else if (bus.wr_en) begin
			aw_got_reg <= 1'b0;
		end else if (!aw_got_reg && !o_s_axi_bvalid) begin
			o_s_axi_awready <= 1'b1;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_s_axi_wready <= 1'b0;
			w_got_reg <= 1'b0;
			bus.wr_data <= 32'h0;
			bus.wr_strb <= 4'h0;
		end else if (i_s_axi_wvalid && o_s_axi_wready) begin
			o_s_axi_wready <= 1'b0;
			w_got_reg <= 1'b1;
			bus.wr_data <= i_s_axi_wdata;
			bus.wr_strb <= i_s_axi_wstrb;
		end else if (bus.wr_en) begin
			w_got_reg <= 1'b0;
		end else if (!w_got_reg && !o_s_axi_bvalid) begin
			o_s_axi_wready <= 1'b1;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `BFI_RESP_OKAY;
		end else if (bus.wr_en) begin
			o_s_axi_bvalid <= 1'b1;
			o_s_axi_bresp <= bus.wr_hit ? `BFI_RESP_OKAY : `BFI_RESP_SLVERR;
		end else if (i_s_axi_bready) begin
			o_s_axi_bvalid <= 1'b0;
		end
	end
	// ----------------------------------------
	// Read path
	// ----------------------------------------
	assign bus.rd_addr = i_s_axi_araddr;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0;
			o_s_axi_rresp <= `BFI_RESP_OKAY;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rdata <= bus.rd_data;
			o_s_axi_rresp <= bus.rd_hit ? `BFI_RESP_OKAY : `BFI_RESP_SLVERR;
		end else if (o_s_axi_rvalid) begin
			if (i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end else begin
			o_s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: bfi_field_unit.sv
// Purpose: Field align, merge and flag logic
// Assumes: Width 1 to 32, shift below 64
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "bfi_defs.svh"
module bfi_field_unit (
	// Operand window and field position
	input wire logic [63:0] i_win,
	input wire logic [5:0] i_shift,
	input wire logic [5:0] i_width,
	input wire logic i_rot32,
	// Insert source and operation select
	input wire logic [31:0] i_src,
	input wire logic i_insert,
	input wire logic i_fill,
	// Results
	output logic [63:0] o_result,
	output logic o_neg,
	output logic o_zero
);
	function automatic logic [63:0] rotl(input logic [63:0] x, input logic [5:0] s);
		logic [127:0] t;
		t = {x, x} << s;
		return t[127:64];
	endfunction
	function automatic logic [63:0] rotr(input logic [63:0] x, input logic [5:0] s);
		logic [127:0] t;
		t = {x, x} >> s;
		return t[63:0];
	endfunction
	logic [63:0] aligned, mask, placed, merged, fld, back;
	always_comb begin
		aligned = rotl(i_win, i_shift);
		mask = {64{1'b1}} << (`BFI_WIN_W - {1'b0, i_width});
		placed = {i_src, 32'h0} << (`BFI_REG_W - {1'b0, i_width});
		merged = aligned;
		if (i_insert) begin
			merged = (aligned & ~mask) | (placed & mask);
		end else if (i_fill) begin
			merged = aligned | mask;
		end
		fld = i_insert ? (placed & mask) : (aligned & mask);
		o_neg = fld[63];
		o_zero = (fld == 64'h0);
		back = rotr(i_rot32 ? {merged[63:32], merged[63:32]} : merged, i_shift);
		o_result = i_rot32 ? {32'h0, back[63:32]} : back;
	end
endmodule
`default_nettype wire

// File: bfi_top.sv
// Purpose: Bit-field insert, test-and-fill and test-only datapath
// Assumes: Core loads operands over AXI4-Lite and writes results back
// Notes: One operation per start, result two cycles later
// How it works
// - Insert copies source low bits into field
// - Insert flags come from inserted value
// - N is field MSB; V,C cleared; X kept
// - Z set when whole field is zero
// - Fill tests original field, then sets ones
// - Test only updates flags, operand unchanged
// - Field located by start offset and width
// - Immediate offset is unsigned 0 to 31
// - Register offset number in bits 8-6
// - Register offset is signed 32-bit value
// - Register width number in bits 2-0
// - Immediate width zero means 32 bits
// - Register width taken modulo 32
// - Insert and fill accept listed modes only
// - Test also accepts PC-relative operands
// - Insert source register from extension bits
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bfi_defs.svh"
module bfi_top (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// AXI4-Lite write
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	// AXI4-Lite read
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [7:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			r[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
		end
		return r;
	endfunction
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `BFI_OFF_INFO);
	endfunction
	function automatic logic ea_legal(input bfi_pkg::bfi_op_t op, input logic [2:0] m,
		input logic [2:0] r);
		logic ok;
		ok = 1'b0;
		unique case (m)
			`BFI_EA_DREG, `BFI_EA_INDIR, `BFI_EA_DISP, `BFI_EA_INDEX: ok = 1'b1;
			`BFI_EA_EXT: begin
				ok = (r == `BFI_EA_ABSW) || (r == `BFI_EA_ABSL) ||
					((op == bfi_pkg::BFI_OP_TEST) &&
					((r == `BFI_EA_PCDISP) || (r == `BFI_EA_PCIDX)));
			end
			default: ok = 1'b0;
		endcase
		return ok && (op != bfi_pkg::BFI_OP_BAD);
	endfunction
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	bfi_reg_if regs ();
	bfi_pkg::bfi_state_t state_reg, state_next;
	bfi_pkg::bfi_op_t op;
	logic [15:0] opword_reg, ext_reg;
	logic [4:0] ccr_reg;
	logic [31:0] offv_reg, widv_reg, srcv_reg, ophi_reg, oplo_reg;
	logic [31:0] rshi_reg, rslo_reg, disp_reg;
	logic [17:0] info_reg;
	logic done_reg, ill_reg;
	logic idle, exec, wr, start, rsv_ok, legal, dreg_mode;
	logic [31:0] wd, off32, disp_calc;
	logic [4:0] wid5;
	logic [5:0] width, shift;
	logic [63:0] win, result;
	logic f_neg, f_zero;
	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	bfi_axil_slave u_bus (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_s_axi_awvalid(i_s_axi_awvalid),
		.o_s_axi_awready(o_s_axi_awready),
		.i_s_axi_awaddr(i_s_axi_awaddr),
		.i_s_axi_wvalid(i_s_axi_wvalid),
		.o_s_axi_wready(o_s_axi_wready),
		.i_s_axi_wdata(i_s_axi_wdata),
		.i_s_axi_wstrb(i_s_axi_wstrb),
		.o_s_axi_bvalid(o_s_axi_bvalid),
		.i_s_axi_bready(i_s_axi_bready),
		.o_s_axi_bresp(o_s_axi_bresp),
		.i_s_axi_arvalid(i_s_axi_arvalid),
		.o_s_axi_arready(o_s_axi_arready),
		.i_s_axi_araddr(i_s_axi_araddr),
		.o_s_axi_rvalid(o_s_axi_rvalid),
		.i_s_axi_rready(i_s_axi_rready),
		.o_s_axi_rdata(o_s_axi_rdata),
		.o_s_axi_rresp(o_s_axi_rresp),
		.bus(regs)
	);
	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	assign idle = (state_reg == bfi_pkg::BFI_ST_IDLE);
	assign exec = (state_reg == bfi_pkg::BFI_ST_EXEC);
	assign wr = regs.wr_en && idle;
	assign wd = regs.wr_data;
	assign regs.wr_hit = mapped(regs.wr_addr);
	assign start = wr && (regs.wr_addr == `BFI_OFF_CTRL) && regs.wr_strb[0] &&
		wd[`BFI_CTRL_START];
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			opword_reg <= 16'h0;
			ext_reg <= 16'h0;
			offv_reg <= 32'h0;
			widv_reg <= 32'h0;
			srcv_reg <= 32'h0;
			ophi_reg <= 32'h0;
			oplo_reg <= 32'h0;
		end else if (wr) begin
			unique case (regs.wr_addr)
				`BFI_OFF_OPWORD: opword_reg <= 16'(merge({16'h0, opword_reg}, wd, regs.wr_strb));
				`BFI_OFF_EXT: ext_reg <= 16'(merge({16'h0, ext_reg}, wd, regs.wr_strb));
				`BFI_OFF_OFFV: offv_reg <= merge(offv_reg, wd, regs.wr_strb);
				`BFI_OFF_WIDV: widv_reg <= merge(widv_reg, wd, regs.wr_strb);
				`BFI_OFF_SRCV: srcv_reg <= merge(srcv_reg, wd, regs.wr_strb);
				`BFI_OFF_OPHI: ophi_reg <= merge(ophi_reg, wd, regs.wr_strb);
				`BFI_OFF_OPLO: oplo_reg <= merge(oplo_reg, wd, regs.wr_strb);
				default: ;
			endcase
		end
	end
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			bfi_pkg::BFI_ST_IDLE: if (start) state_next = bfi_pkg::BFI_ST_EXEC;
			bfi_pkg::BFI_ST_EXEC: state_next = bfi_pkg::BFI_ST_IDLE;
		endcase
	end
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_reg <= bfi_pkg::BFI_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end
	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	always_comb begin
		if (opword_reg[`BFI_OPC_FIELD] == `BFI_OPC_INSERT) begin
			op = bfi_pkg::BFI_OP_INS;
		end else if (opword_reg[`BFI_OPC_FIELD] == `BFI_OPC_FILL) begin
			op = bfi_pkg::BFI_OP_FILL;
		end else if (opword_reg[`BFI_OPC_FIELD] == `BFI_OPC_TEST) begin
			op = bfi_pkg::BFI_OP_TEST;
		end else begin
			op = bfi_pkg::BFI_OP_BAD;
		end
	end
	assign rsv_ok = !ext_reg[`BFI_X_TOP] &&
		(!ext_reg[`BFI_X_DO] || (ext_reg[`BFI_X_ORSV] == 2'h0)) &&
		(!ext_reg[`BFI_X_DW] || (ext_reg[`BFI_X_WRSV] == 2'h0)) &&
		((op == bfi_pkg::BFI_OP_INS) || (ext_reg[`BFI_X_SRC] == 3'h0));
	assign legal = ea_legal(op, opword_reg[`BFI_EA_MODE], opword_reg[`BFI_EA_REG]) && rsv_ok;
	assign dreg_mode = (opword_reg[`BFI_EA_MODE] == `BFI_EA_DREG);
	assign off32 = ext_reg[`BFI_X_DO] ? offv_reg : {27'h0, ext_reg[`BFI_X_OFF]};
	assign wid5 = ext_reg[`BFI_X_DW] ? widv_reg[4:0] : ext_reg[`BFI_X_WID];
	assign width = (wid5 == 5'h0) ? `BFI_FULL_W : {1'b0, wid5};
	assign shift = dreg_mode ? {1'b0, off32[4:0]} : {3'h0, off32[2:0]};
	assign disp_calc = 32'($signed(off32) >>> `BFI_BYTE_SH);
	assign win = dreg_mode ? {oplo_reg, oplo_reg} : {ophi_reg, oplo_reg};
	bfi_field_unit u_field (
		.i_win(win),
		.i_shift(shift),
		.i_width(width),
		.i_rot32(dreg_mode),
		.i_src(srcv_reg),
		.i_insert(op == bfi_pkg::BFI_OP_INS),
		.i_fill(op == bfi_pkg::BFI_OP_FILL),
		.o_result(result),
		.o_neg(f_neg),
		.o_zero(f_zero)
	);
	// ----------------------------------------
	// Results and flags
	// ----------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rshi_reg <= 32'h0;
			rslo_reg <= 32'h0;
			disp_reg <= 32'h0;
			info_reg <= 18'h0;
		end else if (exec) begin
			rshi_reg <= (legal && !dreg_mode) ? result[63:32] : ophi_reg;
			rslo_reg <= legal ? result[31:0] : oplo_reg;
			disp_reg <= dreg_mode ? 32'h0 : disp_calc;
			info_reg <= {!dreg_mode, legal && (op != bfi_pkg::BFI_OP_TEST), 5'h0,
				ext_reg[`BFI_X_WREG], 1'b0, ext_reg[`BFI_X_OREG], 1'b0,
				ext_reg[`BFI_X_SRC]};
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ccr_reg <= 5'h0;
		end else if (exec && legal) begin
			ccr_reg[`BFI_CCR_N] <= f_neg;
			ccr_reg[`BFI_CCR_Z] <= f_zero;
			ccr_reg[`BFI_CCR_V] <= 1'b0;
			ccr_reg[`BFI_CCR_C] <= 1'b0;
		end else if (wr && (regs.wr_addr == `BFI_OFF_CCR) && regs.wr_strb[0]) begin
			ccr_reg <= wd[4:0];
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			done_reg <= 1'b0;
			ill_reg <= 1'b0;
		end else if (exec) begin
			done_reg <= 1'b1;
			ill_reg <= !legal;
		end else if (start) begin
			done_reg <= 1'b0;
		end
	end
	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	assign regs.rd_hit = mapped(regs.rd_addr);
	always_comb begin
		unique case (regs.rd_addr)
			`BFI_OFF_STATUS: regs.rd_data = {29'h0, ill_reg, done_reg, exec};
			`BFI_OFF_OPWORD: regs.rd_data = {16'h0, opword_reg};
			`BFI_OFF_EXT: regs.rd_data = {16'h0, ext_reg};
			`BFI_OFF_CCR: regs.rd_data = {27'h0, ccr_reg};
			`BFI_OFF_OFFV: regs.rd_data = offv_reg;
			`BFI_OFF_WIDV: regs.rd_data = widv_reg;
			`BFI_OFF_SRCV: regs.rd_data = srcv_reg;
			`BFI_OFF_OPHI: regs.rd_data = ophi_reg;
			`BFI_OFF_OPLO: regs.rd_data = oplo_reg;
			`BFI_OFF_RSHI: regs.rd_data = rshi_reg;
			`BFI_OFF_RSLO: regs.rd_data = rslo_reg;
			`BFI_OFF_DISP: regs.rd_data = disp_reg;
			`BFI_OFF_INFO: regs.rd_data = {14'h0, info_reg};
			default: regs.rd_data = 32'h0;
		endcase
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	logic exec_ok, ins_zero, ins_msb;
	logic [32:0] ins_mask;
	assign exec_ok = exec && legal;
	assign ins_mask = (33'h1 << width) - 33'h1;
	assign ins_zero = ((srcv_reg & ins_mask[31:0]) == 32'h0);
	assign ins_msb = srcv_reg[5'(width - 6'h1)];
	ccr_vc_clear_a: assert property (
		exec_ok |=> !ccr_reg[`BFI_CCR_V] && !ccr_reg[`BFI_CCR_C] &&
		(ccr_reg[`BFI_CCR_X] == $past(ccr_reg[`BFI_CCR_X])))
		else $error("V or C not cleared, or X changed");
	insert_zero_a: assert property (
		(exec_ok && (op == bfi_pkg::BFI_OP_INS)) |=> ccr_reg[`BFI_CCR_Z] == $past(ins_zero))
		else $error("insert Z not from inserted value");
	insert_neg_a: assert property (
		(exec_ok && (op == bfi_pkg::BFI_OP_INS)) |=> ccr_reg[`BFI_CCR_N] == $past(ins_msb))
		else $error("insert N not from inserted MSB");
	test_keep_a: assert property (
		(exec_ok && (op == bfi_pkg::BFI_OP_TEST)) |=>
		(rslo_reg == $past(oplo_reg)) && (rshi_reg == $past(ophi_reg)) && !info_reg[16])
		else $error("test-only changed the operand");
	fill_ones_a: assert property (
		(exec_ok && (op == bfi_pkg::BFI_OP_FILL)) |=> (rslo_reg & $past(oplo_reg)) == $past(oplo_reg))
		else $error("fill cleared a bit");
	wid_zero_a: assert property (
		(exec_ok && (op == bfi_pkg::BFI_OP_FILL) && dreg_mode && (wid5 == 5'h0)) |=>
		rslo_reg == 32'hFFFFFFFF)
		else $error("width zero did not fill 32 bits");
	illegal_hold_a: assert property (
		(exec && !legal) |=> ill_reg && $stable(ccr_reg) && (rslo_reg == $past(oplo_reg)))
		else $error("illegal form changed state");
	pc_rel_a: assert property (
		(exec && rsv_ok && (opword_reg[`BFI_EA_MODE] == `BFI_EA_EXT) &&
		(opword_reg[`BFI_EA_REG] == `BFI_EA_PCIDX)) |=>
		ill_reg == ($past(op) != bfi_pkg::BFI_OP_TEST))
		else $error("PC-relative legality wrong");
	opc_bad_a: assert property (
		(exec && (op == bfi_pkg::BFI_OP_BAD)) |=> ill_reg)
		else $error("unknown opcode accepted");
	disp_sign_a: assert property (
		(exec_ok && !dreg_mode) |=>
		({disp_reg[28:0], 3'h0} == ($past(off32) & 32'hFFFFFFF8)) &&
		((disp_reg[31:28] == 4'h0) || (disp_reg[31:28] == 4'hF)) &&
		(($signed(disp_reg) < 32'sh0) == ($signed($past(off32)) < 32'sh0)))
		else $error("byte displacement wrong");
	start_done_a: assert property (
		start |=> exec ##1 (idle && done_reg))
		else $error("start did not complete in two cycles");
	ins_cov: cover property (exec_ok && (op == bfi_pkg::BFI_OP_INS));
	fill_mem_cov: cover property (exec_ok && (op == bfi_pkg::BFI_OP_FILL) && !dreg_mode);
	test_reg_cov: cover property (exec_ok && (op == bfi_pkg::BFI_OP_TEST) && ext_reg[`BFI_X_DO]);
	illegal_cov: cover property (exec && !legal);
endmodule
`default_nettype wire

// File: bfi_core_model.sv
// Purpose: Core side model that loads and reads the unit registers
// Assumes: One write or one read under way at a time
// Notes: o_hang rises when an answer does not come
`timescale 1ns/1ps
`default_nettype none
module bfi_core_model (
	// Clock
	input wire logic i_clk,
	// Requests and hang flag
	output logic o_awv,
	output logic [7:0] o_awa,
	output logic o_wv,
	output logic [31:0] o_wd,
	output logic [3:0] o_ws,
	output logic o_br,
	output logic o_arv,
	output logic [7:0] o_ara,
	output logic o_rr,
	output logic o_hang,
	// Answers
	input wire logic i_awr,
	input wire logic i_wr,
	input wire logic i_bv,
	input wire logic [1:0] i_bre,
	input wire logic i_arr,
	input wire logic i_rv,
	input wire logic [31:0] i_rd,
	input wire logic [1:0] i_rre
);
	initial {o_awv, o_awa, o_wv, o_wd, o_ws, o_br, o_arv, o_ara, o_rr, o_hang} = '0;
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n = 0;
		r = 2'h3;
		@(posedge i_clk);
		{o_awv, o_wv, o_br} <= 3'h7;
		{o_awa, o_wd, o_ws} <= {a, d, s};
		do begin
			@(posedge i_clk);
			n++;
			if (o_awv && i_awr)
				o_awv <= 1'b0;
			if (o_wv && i_wr)
				o_wv <= 1'b0;
		end while (i_bv !== 1'b1 && n < 64);
		o_br <= 1'b0;
		if (i_bv === 1'b1)
			r = i_bre;
		else
			o_hang <= 1'b1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		{d, r} = '1;
		@(posedge i_clk);
		{o_arv, o_rr} <= 2'h3;
		o_ara <= a;
		do begin
			@(posedge i_clk);
			n++;
			if (o_arv && i_arr)
				o_arv <= 1'b0;
		end while (i_rv !== 1'b1 && n < 64);
		o_rr <= 1'b0;
		if (i_rv === 1'b1)
			{d, r} = {i_rd, i_rre};
		else
			o_hang <= 1'b1;
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench of the bit-field unit
// Assumes: Register map of the unit
// Notes: Expected values worked out here
`timescale 1ns/1ps
`default_nettype none
`include "bfi_defs.svh"
module testbench;
	localparam logic [31:0] SRC = 32'h12345680;
	localparam logic [15:0] OPS [3] = '{16'hEFC0, 16'hEEC0, 16'hE8C0};
	localparam logic [11:0] LEG [3] = '{12'h1E5, 12'h1E5, 12'h7E5};
	localparam logic [5:0] EAS [12] = '{6'h00, 6'h08, 6'h10, 6'h18, 6'h20, 6'h28,
		6'h30, 6'h38, 6'h39, 6'h3A, 6'h3B, 6'h3C};
	localparam logic [7:0] ADR [9] = '{`BFI_OFF_OPWORD, `BFI_OFF_EXT, `BFI_OFF_OFFV,
		`BFI_OFF_WIDV, `BFI_OFF_SRCV, `BFI_OFF_OPHI, `BFI_OFF_OPLO, `BFI_OFF_CCR,
		`BFI_OFF_CTRL};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awv, awr, wvl, wrd, bvl, brd, arv, arr, rvl, rrd, hang;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd;
	logic [3:0] ws;
	logic [1:0] bre, rre;
	int num_errors = 0;
	int checks = 0;
	initial forever #5 clk = ~clk;
	bfi_top dut (.i_core_clk(clk), .i_sys_rst(rst), .i_s_axi_awvalid(awv),
		.o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wvl),
		.o_s_axi_wready(wrd), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
		.o_s_axi_bvalid(bvl), .i_s_axi_bready(brd), .o_s_axi_bresp(bre),
		.i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
		.o_s_axi_rvalid(rvl), .i_s_axi_rready(rrd), .o_s_axi_rdata(rd),
		.o_s_axi_rresp(rre));
	bfi_core_model core (.i_clk(clk), .o_awv(awv), .o_awa(awa), .o_wv(wvl), .o_wd(wd),
		.o_ws(ws), .o_br(brd), .o_arv(arv), .o_ara(ara), .o_rr(rrd), .o_hang(hang),
		.i_awr(awr), .i_wr(wrd), .i_bv(bvl), .i_bre(bre), .i_arr(arr), .i_rv(rvl),
		.i_rd(rd), .i_rre(rre));
	task automatic summarize();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] s;
		core.wr(a, d, 4'hF, s);
		chk("bresp", 32'h0, {30'h0, s});
	endtask
	task automatic r(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] s;
		core.rd(a, d, s);
		chk("rresp", 32'h0, {30'h0, s});
	endtask
	function automatic logic [31:0] rotl(input logic [31:0] x, input int o);
		return (x << o) | (x >> (32 - o));
	endfunction
	// ----
	// One operation: load, start, poll, compare
	// ----
	task automatic run(input logic [15:0] op, input logic [15:0] ex, input logic [31:0] ov,
		input logic [31:0] wv, input logic [31:0] v, input logic ok);
		logic mem, ins;
		logic [31:0] o, m, rt, nt, fv, d;
		logic [31:0] vals [9];
		logic signed [31:0] so;
		int eo, n, wn;
		mem = op[5:3] != 3'h0;
		ins = op[15:6] == 10'h3BF;
		o = ex[11] ? ov : {27'h0, ex[10:6]};
		so = o;
		so = so >>> 3;
		eo = mem ? o[2:0] : o[4:0];
		d = ex[5] ? wv : {27'h0, ex[4:0]};
		wn = d[4:0] == 5'h0 ? 32 : d[4:0];
		m = 32'hFFFFFFFF << (32 - wn);
		rt = rotl(v, eo);
		nt = ins ? SRC << (32 - wn) : op[15:6] == 10'h3BB ? m : rt;
		fv = ins ? nt : rt;
		vals = '{{16'h0, op}, {16'h0, ex}, ov, wv, SRC, v, v, 32'h1F, 32'h1};
		for (int i = 0; i < 9; i++)
			w(ADR[i], vals[i]);
		n = 0;
		do begin
			r(`BFI_OFF_STATUS, d);
			n++;
		end while (d[1] !== 1'b1 && n < 20);
		if (d[1] !== 1'b1) begin
			num_errors++;
			summarize();
		end
		chk("status", ok ? 32'h2 : 32'h6, d);
		r(`BFI_OFF_CCR, d);
		chk("ccr", ok ? {27'h0, 1'b1, fv[31], (fv & m) == 32'h0, 2'h0} : 32'h1F, d);
		r(mem ? `BFI_OFF_RSHI : `BFI_OFF_RSLO, d);
		chk("result", ok ? rotl((rt & ~m) | (nt & m), 32 - eo) : v, d);
		if (ok) begin
			r(`BFI_OFF_DISP, d);
			chk("disp", mem ? so : 32'h0, d);
			r(`BFI_OFF_INFO, d);
			chk("info", {14'h0, mem, op[15:6] != 10'h3A3, 5'h0, ex[2:0], 1'b0, ex[8:6], 1'b0,
				ex[14:12]}, d);
		end
		$display("test %h %h done", op, ex);
	endtask
	always @(posedge hang) begin
		num_errors++;
		summarize();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] s;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		r(`BFI_OFF_CCR, d);
		chk("ccr reset", 32'h0, d);
		core.wr(8'h40, 32'h1, 4'hF, s);
		chk("unmapped bresp", 32'h2, {30'h0, s});
		core.rd(8'h40, d, s);
		chk("unmapped rresp", 32'h2, {30'h0, s});
		w(`BFI_OFF_OPLO, 32'h0);
		core.wr(`BFI_OFF_OPLO, 32'hFFFFFFFF, 4'h2, s);
		r(`BFI_OFF_OPLO, d);
		chk("strobe", 32'h0000FF00, d);
		$display("test registers done");
		run(16'hEFC0, 16'h1700, 32'h0, 32'h0, 32'hCAFE1234, 1'b1);
		run(16'hEFC0, 16'h38A1, 32'hFFFFFFFD, 32'h23, 32'hFFFFFFFF, 1'b1);
		run(16'hEED3, 16'h050C, 32'h0, 32'h0, 32'h00F00000, 1'b1);
		run(16'hEEC0, 16'h0023, 32'h0, 32'h20, 32'h0, 1'b1);
		run(16'hE8FA, 16'h0909, 32'hFFFFFFFD, 32'h0, 32'h04000000, 1'b1);
		run(16'hEEC0, 16'h1108, 32'h0, 32'h0, 32'h1, 1'b0);
		run(16'hEFC0, 16'h0A08, 32'h0, 32'h0, 32'h1, 1'b0);
		run(16'hEFC0, 16'h0038, 32'h0, 32'h0, 32'h1, 1'b0);
		run(16'hEAC0, 16'h0108, 32'h0, 32'h0, 32'h1, 1'b0);
		for (int p = 0; p < 3; p++)
			for (int k = 0; k < 12; k++)
				run(OPS[p] | {10'h0, EAS[k]}, 16'h0108, 32'h0, 32'h0, 32'h0F0F0F0F, LEG[p][k]);
		summarize();
	end
endmodule
`default_nettype wire
